/* File: gpio_port_function_mux.sv */
// eight-line port function multiplexer with axi4-lite register slave
// How it works
// - select register at zero, resets zero
// - line 7: gpio, trig3, sync7, irq1
// - line 6: gpio, trig2, sync6, irq0
// - line 5: gpio, trig1, sync5, ext clock
// - line 4: gpio, trig0, sync4, irq1
// - line 3: gpio, trig3, sync3, irq0
// - line 2: por out, trig2, sync2
// - line 2 code 11: external clock in
// - irq line high while pending, low cleared
//
// Implementation choice: register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
module gpio_port_function_mux
  import pin_mux_pkg::*;
#(
  parameter int LINES = NUM_LINES
) (
  // clock and reset
  input  wire logic                core_clk,
  input  wire logic                arst_n,
  // axi4-lite write address
  input  wire logic                s_axi_awvalid,
  output logic                     s_axi_awready,
  input  wire logic [ADDR_W-1:0]   s_axi_awaddr,
  input  wire logic [2:0]          s_axi_awprot,
  // axi4-lite write data
  input  wire logic                s_axi_wvalid,
  output logic                     s_axi_wready,
  input  wire logic [DATA_W-1:0]   s_axi_wdata,
  input  wire logic [3:0]          s_axi_wstrb,
  // axi4-lite write response
  output logic                     s_axi_bvalid,
  input  wire logic                s_axi_bready,
  output logic [1:0]               s_axi_bresp,
  // axi4-lite read address
  input  wire logic                s_axi_arvalid,
  output logic                     s_axi_arready,
  input  wire logic [ADDR_W-1:0]   s_axi_araddr,
  input  wire logic [2:0]          s_axi_arprot,
  // axi4-lite read data
  output logic                     s_axi_rvalid,
  input  wire logic                s_axi_rready,
  output logic [DATA_W-1:0]        s_axi_rdata,
  output logic [1:0]               s_axi_rresp,
  // internal sources
  input  wire logic [LINES-1:0]    ext_sync_level,
  input  wire logic [NUM_IRQ-1:0]  irq_pending,
  input  wire logic                por_flag,
  // pins
  input  wire logic [LINES-1:0]    pin_in,
  output logic      [LINES-1:0]    pin_out,
  output logic      [LINES-1:0]    pin_oe,
  // to sequencer and clock logic
  output logic [NUM_TRIG-1:0]      seq_trigger,
  output logic                     external_clock_in,
  output logic [LINES-1:0]         gpio_in_level
);
  logic               awready_r, awready_nxt;
  logic               wready_r, wready_nxt;
  logic               arready_r, arready_nxt;

  logic [SEL_W-1:0]   port_function_select_r, port_function_select_nxt;
  logic [LINES-1:0]   port_output_drive_enable_r, port_output_drive_enable_nxt;
  logic [LINES-1:0]   out_data_r, out_data_nxt;
  logic [LINES-1:0]   pin_sync;
  logic [LINES-1:0]   pin_out_r, pin_out_nxt;
  logic [LINES-1:0]   pin_oe_r, pin_oe_nxt;
  logic [NUM_TRIG-1:0] trig_r, trig_nxt;
  logic               external_clock_in_r, external_clock_in_nxt;
  logic [LINES-1:0]   gin_r, gin_nxt;
  logic               aw_held_r, aw_held_nxt;
  logic               w_held_r, w_held_nxt;
  logic [ADDR_W-1:0]  awaddr_r, awaddr_nxt;
  logic [DATA_W-1:0]  wdata_r, wdata_nxt;
  logic [3:0]         wstrb_r, wstrb_nxt;
  logic               bvalid_r, bvalid_nxt;
  logic [1:0]         bresp_r, bresp_nxt;
  logic               rvalid_r, rvalid_nxt;
  logic [DATA_W-1:0]  rdata_r, rdata_nxt;
  logic [1:0]         rresp_r, rresp_nxt;
  logic               do_write;
  logic               do_read;

  // per-line function code
  function automatic logic [1:0] line_code(input logic [SEL_W-1:0] sel, input int idx);
    line_code = sel[idx*CODE_W +: CODE_W];
  endfunction : line_code

  function automatic logic addr_known(input logic [ADDR_W-1:0] a);
    addr_known = (a == FUNC_SEL_ADDR) || (a == DRIVE_EN_ADDR) || (a == OUT_DATA_ADDR)
              || (a == IN_DATA_ADDR) || (a == PIN_LEVEL_ADDR);
  endfunction : addr_known

  // lines 2 and 5 can take the external clock; both feed one input
  function automatic logic clock_line(input int idx);
    clock_line = (idx == 2) || (idx == 5);
  endfunction : clock_line

  // lines 3 and 6 carry irq0, lines 4 and 7 carry irq1
  function automatic logic irq_of_line(input int idx);
    irq_of_line = (idx == 4) || (idx == 7);
  endfunction : irq_of_line

  // merge byte lanes into a stored word
  function automatic logic [DATA_W-1:0] merge(input logic [DATA_W-1:0] old,
                                             input logic [DATA_W-1:0] wd,
                                             input logic [3:0]        st);
    merge = old;
    for (int b = 0; b < 4; b++) begin
      if (st[b]) begin
        merge[b*8 +: 8] = wd[b*8 +: 8];
      end
    end
  endfunction : merge

  // pins cross into core_clk before any decode
  level_sync #(.W(LINES)) u_pin_sync (
    .core_clk (core_clk),
    .arst_n   (arst_n),
    .async_in (pin_in),
    .sync_out (pin_sync)
  );

  // axi write side: address and data accepted in either order
  always_comb begin
    aw_held_nxt = aw_held_r;
    w_held_nxt  = w_held_r;
    awaddr_nxt  = awaddr_r;
    wdata_nxt   = wdata_r;
    wstrb_nxt   = wstrb_r;
    bvalid_nxt  = bvalid_r;
    bresp_nxt   = bresp_r;
    port_function_select_nxt     = port_function_select_r;
    port_output_drive_enable_nxt = port_output_drive_enable_r;
    out_data_nxt                 = out_data_r;
    if (s_axi_awvalid && !aw_held_r && !bvalid_r) begin
      aw_held_nxt = 1'b1;
      awaddr_nxt  = s_axi_awaddr;
    end
    if (s_axi_wvalid && !w_held_r && !bvalid_r) begin
      w_held_nxt = 1'b1;
      wdata_nxt  = s_axi_wdata;
      wstrb_nxt  = s_axi_wstrb;
    end
    if (do_write) begin
      aw_held_nxt = 1'b0;
      w_held_nxt  = 1'b0;
      bvalid_nxt  = 1'b1;
      bresp_nxt   = addr_known(awaddr_r) ? RESP_OKAY : RESP_SLVERR;
      unique case (awaddr_r)
        FUNC_SEL_ADDR: port_function_select_nxt = SEL_W'(merge(
          {{(DATA_W-SEL_W){1'b0}}, port_function_select_r}, wdata_r, wstrb_r));
        DRIVE_EN_ADDR: port_output_drive_enable_nxt = LINES'(merge(
          {{(DATA_W-LINES){1'b0}}, port_output_drive_enable_r}, wdata_r, wstrb_r));
        OUT_DATA_ADDR: out_data_nxt = LINES'(merge(
          {{(DATA_W-LINES){1'b0}}, out_data_r}, wdata_r, wstrb_r));
        default: ;
      endcase
    end
    if (bvalid_r && s_axi_bready) begin
      bvalid_nxt = 1'b0;
    end
    // ready leaves a flop, so it follows the next held state
    awready_nxt = !aw_held_nxt && !bvalid_nxt;
    wready_nxt  = !w_held_nxt && !bvalid_nxt;
  end

  assign do_write = aw_held_r && w_held_r && !bvalid_r;

  // axi read side: one cycle to data
  assign do_read = s_axi_arvalid && !rvalid_r;

  always_comb begin
    rvalid_nxt = rvalid_r;
    rdata_nxt  = rdata_r;
    rresp_nxt  = rresp_r;
    if (do_read) begin
      rvalid_nxt = 1'b1;
      rresp_nxt  = addr_known(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
      unique case (s_axi_araddr)
        FUNC_SEL_ADDR:  rdata_nxt = DATA_W'(port_function_select_r);
        DRIVE_EN_ADDR:  rdata_nxt = DATA_W'(port_output_drive_enable_r);
        OUT_DATA_ADDR:  rdata_nxt = DATA_W'(out_data_r);
        IN_DATA_ADDR:   rdata_nxt = DATA_W'(gin_r);
        PIN_LEVEL_ADDR: rdata_nxt = DATA_W'(pin_sync);
        default:        rdata_nxt = '0;
      endcase
    end else if (rvalid_r && s_axi_rready) begin
      rvalid_nxt = 1'b0;
    end
    arready_nxt = !rvalid_nxt;
  end

  // function multiplex
  always_comb begin
    pin_out_nxt = out_data_r;
    pin_oe_nxt  = port_output_drive_enable_r;
    trig_nxt    = '0;
    external_clock_in_nxt  = 1'b0;
    gin_nxt     = '0;
    for (int i = 2; i < LINES; i++) begin
      unique case (line_code(port_function_select_r, i))
        CODE_00: begin
          if (i == 2) begin
            pin_out_nxt[i] = por_flag;
            pin_oe_nxt[i]  = 1'b1;
          end else begin
            gin_nxt[i] = pin_sync[i];
          end
        end
        CODE_01: begin
          // trigger index repeats every four lines
          trig_nxt[i % NUM_TRIG] = trig_nxt[i % NUM_TRIG] | pin_sync[i];
          pin_oe_nxt[i] = 1'b0;
        end
        CODE_10: begin
          // driver must already be enabled by software
          pin_out_nxt[i] = ext_sync_level[i];
        end
        CODE_11: begin
          if (clock_line(i)) begin
            external_clock_in_nxt    = external_clock_in_nxt | pin_sync[i];
            pin_oe_nxt[i] = 1'b0;
          end else begin
            pin_out_nxt[i] = irq_pending[irq_of_line(i)];
            pin_oe_nxt[i]  = 1'b1;
          end
        end
      endcase
    end
    // lines 1 and 0 are left as plain gpio
    for (int i = 0; i < 2; i++) begin
      gin_nxt[i] = pin_sync[i];
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      port_function_select_r     <= FUNC_SEL_RST;
      port_output_drive_enable_r <= DRIVE_EN_RST;
      out_data_r                 <= OUT_DATA_RST;
      aw_held_r <= 1'b0;
      w_held_r  <= 1'b0;
      awaddr_r  <= '0;
      wdata_r   <= '0;
      wstrb_r   <= '0;
      bvalid_r  <= 1'b0;
      bresp_r   <= RESP_OKAY;
      rvalid_r  <= 1'b0;
      rdata_r   <= '0;
      rresp_r   <= RESP_OKAY;
      pin_out_r <= '0;
      pin_oe_r  <= '0;
      trig_r    <= '0;
      external_clock_in_r  <= 1'b0;
      gin_r     <= '0;
      awready_r <= 1'b1;
      wready_r  <= 1'b1;
      arready_r <= 1'b1;
    end else begin
      port_function_select_r     <= port_function_select_nxt;
      port_output_drive_enable_r <= port_output_drive_enable_nxt;
      out_data_r                 <= out_data_nxt;
      aw_held_r <= aw_held_nxt;
      w_held_r  <= w_held_nxt;
      awaddr_r  <= awaddr_nxt;
      wdata_r   <= wdata_nxt;
      wstrb_r   <= wstrb_nxt;
      bvalid_r  <= bvalid_nxt;
      bresp_r   <= bresp_nxt;
      rvalid_r  <= rvalid_nxt;
      rdata_r   <= rdata_nxt;
      rresp_r   <= rresp_nxt;
      pin_out_r <= pin_out_nxt;
      pin_oe_r  <= pin_oe_nxt;
      trig_r    <= trig_nxt;
      external_clock_in_r  <= external_clock_in_nxt;
      gin_r     <= gin_nxt;
      awready_r <= awready_nxt;
      wready_r  <= wready_nxt;
      arready_r <= arready_nxt;
    end
  end

  assign s_axi_awready     = awready_r;
  assign s_axi_wready      = wready_r;
  assign s_axi_bvalid      = bvalid_r;
  assign s_axi_bresp       = bresp_r;
  assign s_axi_arready     = arready_r;
  assign s_axi_rvalid      = rvalid_r;
  assign s_axi_rdata       = rdata_r;
  assign s_axi_rresp       = rresp_r;
  assign pin_out           = pin_out_r;
  assign pin_oe            = pin_oe_r;
  assign seq_trigger       = trig_r;
  assign external_clock_in = external_clock_in_r;
  assign gpio_in_level     = gin_r;
endmodule : gpio_port_function_mux
`default_nettype wire

/* File: pin_mux_pkg.sv */
// shared constants for the port function multiplexer
package pin_mux_pkg;
  localparam int          DATA_W           = 32;
  localparam int          ADDR_W           = 8;
  localparam int          NUM_LINES        = 8;
  localparam int          CODE_W           = 2;
  localparam int          SEL_W            = 16;
  // register byte addresses
  localparam logic [7:0]  FUNC_SEL_ADDR    = 8'h00;
  localparam logic [7:0]  DRIVE_EN_ADDR    = 8'h04;
  localparam logic [7:0]  OUT_DATA_ADDR    = 8'h14;
  localparam logic [7:0]  IN_DATA_ADDR     = 8'h10;
  localparam logic [7:0]  PIN_LEVEL_ADDR   = 8'h40;
  // reset values
  localparam logic [15:0] FUNC_SEL_RST     = 16'h0000;
  localparam logic [7:0]  DRIVE_EN_RST     = 8'h00;
  localparam logic [7:0]  OUT_DATA_RST     = 8'h00;
  // function codes
  localparam logic [1:0]  CODE_00          = 2'h0;
  localparam logic [1:0]  CODE_01          = 2'h1;
  localparam logic [1:0]  CODE_10          = 2'h2;
  localparam logic [1:0]  CODE_11          = 2'h3;
  // axi responses
  localparam logic [1:0]  RESP_OKAY        = 2'h0;
  localparam logic [1:0]  RESP_SLVERR      = 2'h2;
  localparam int          NUM_TRIG         = 4;
  localparam int          NUM_IRQ          = 2;
endpackage : pin_mux_pkg

/* File: level_sync.sv */
// two-flop synchroniser for a vector of pin levels
`timescale 1ns/1ps
`default_nettype none
module level_sync #(
  parameter int W = 8
) (
  // clock and reset
  input  wire logic         core_clk,
  input  wire logic         arst_n,
  // levels
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);
  logic [W-1:0] meta_r;
  logic [W-1:0] meta_nxt;
  logic [W-1:0] sync_r;
  logic [W-1:0] sync_nxt;

  always_comb begin
    meta_nxt = async_in;
    sync_nxt = meta_r;
  end

  // first stage feeds only the second stage
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      meta_r <= '0;
      sync_r <= '0;
    end else begin
      meta_r <= meta_nxt;
      sync_r <= sync_nxt;
    end
  end

  assign sync_out = sync_r;
endmodule : level_sync
`default_nettype wire

/* File: pin_mux_chk.sv */
// assertions for the port function multiplexer
`timescale 1ns/1ps
`default_nettype none
module pin_mux_chk
  import pin_mux_pkg::*;
(
  // clock and reset
  input wire logic        core_clk,
  input wire logic        arst_n,
  // register bus
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic [7:0]  s_axi_awaddr,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0]  s_axi_wstrb,
  input wire logic        s_axi_bvalid,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  // sources and pins
  input wire logic [1:0]  irq_pending,
  input wire logic [7:0]  ext_sync_level,
  input wire logic        por_flag,
  input wire logic [7:0]  pin_in,
  input wire logic [7:0]  pin_out,
  input wire logic [7:0]  pin_oe,
  input wire logic [3:0]  seq_trigger,
  input wire logic        external_clock_in
);
  logic [7:0]  a_r, a_nxt;
  logic [15:0] d_r, d_nxt, s_r, s_nxt;
  logic [1:0]  m_r, m_nxt;
  logic [2:0]  c_r, c_nxt;
  logic        b_r;
  // shadow select lags the real one by a cycle, matching the pin register
  always_comb begin
    a_nxt = (s_axi_awvalid && s_axi_awready) ? s_axi_awaddr : a_r;
    d_nxt = (s_axi_wvalid && s_axi_wready) ? s_axi_wdata[15:0] : d_r;
    m_nxt = (s_axi_wvalid && s_axi_wready) ? s_axi_wstrb[1:0] : m_r;
    s_nxt = s_r;
    if (s_axi_bvalid && !b_r && s_axi_bresp == RESP_OKAY && a_r == FUNC_SEL_ADDR) begin
      if (m_r[0]) s_nxt[7:0] = d_r[7:0];
      if (m_r[1]) s_nxt[15:8] = d_r[15:8];
    end
    c_nxt = (s_nxt != s_r) ? 3'h0 : ((c_r == 3'h7) ? c_r : c_r + 3'h1);
  end
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      a_r <= 8'h00;
      d_r <= 16'h0000;
      m_r <= 2'h0;
      s_r <= 16'h0000;
      c_r <= 3'h0;
      b_r <= 1'b0;
    end else begin
      a_r <= a_nxt;
      d_r <= d_nxt;
      m_r <= m_nxt;
      s_r <= s_nxt;
      c_r <= c_nxt;
      b_r <= s_axi_bvalid;
    end
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  AST_L7_IRQ: assert property (c_r > 3 && s_r[15:14] == CODE_11 |->
    pin_oe[7] && pin_out[7] == $past(irq_pending[1])) else $error("line 7 irq wrong");
  AST_L6_SYNC: assert property (c_r > 3 && s_r[13:12] == CODE_10 |->
    pin_out[6] == $past(ext_sync_level[6])) else $error("line 6 sync wrong");
  AST_L5_TRIG: assert property (c_r > 3 && s_r[11:10] == CODE_01 |-> !pin_oe[5])
    else $error("line 5 driven as trigger");
  AST_L4_IRQ: assert property (c_r > 3 && s_r[9:8] == CODE_11 |->
    pin_oe[4] && pin_out[4] == $past(irq_pending[1])) else $error("line 4 irq wrong");
  AST_L3_IRQ: assert property (c_r > 3 && s_r[7:6] == CODE_11 |->
    pin_oe[3] && pin_out[3] == $past(irq_pending[0])) else $error("line 3 irq wrong");
  AST_L2_POR: assert property (c_r > 3 && s_r[5:4] == CODE_00 |->
    pin_oe[2] && pin_out[2] == $past(por_flag)) else $error("line 2 por wrong");
  AST_L2_CLK: assert property (c_r > 3 && s_r[5:4] == CODE_11 && s_r[11:10] != CODE_11 |->
    !pin_oe[2] && external_clock_in == $past(pin_in[2], 3)) else $error("line 2 clock wrong");
  AST_L5_CLK: assert property (c_r > 3 && s_r[11:10] == CODE_11 && s_r[5:4] != CODE_11 |->
    !pin_oe[5] && external_clock_in == $past(pin_in[5], 3)) else $error("line 5 clock wrong");
  AST_TRIG2: assert property (c_r > 3 && s_r[13:12] == CODE_01 && s_r[5:4] != CODE_01 |->
    seq_trigger[2] == $past(pin_in[6], 3)) else $error("trigger 2 wrong");
  AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read answer dropped");
  AST_AR_RDY: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read not answered");
endmodule : pin_mux_chk
bind gpio_port_function_mux pin_mux_chk u_chk (.*);
`default_nettype wire

/* File: pad_model.sv */
// pad model: host levels on lines the device leaves undriven
`timescale 1ns/1ps
`default_nettype none
module pad_model (
  // pads
  input  wire logic [7:0] pin_out,
  input  wire logic [7:0] pin_oe,
  input  wire logic [7:0] host_lvl,
  output logic      [7:0] pin_in
);
  // host level changes every cycle, so a released pad never looks stale
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & host_lvl);
endmodule : pad_model
`default_nettype wire

/* File: tb_gpio_port_function_mux.sv */
// testbench for the port function multiplexer
`timescale 1ns/1ps
`default_nettype none
module tb_gpio_port_function_mux import pin_mux_pkg::*;;
  logic core_clk, arst_n, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic por_flag, external_clock_in, slow;
  logic [7:0] s_axi_awaddr, s_axi_araddr, ext_sync_level, pin_in, pin_out, pin_oe;
  logic [7:0] gpio_in_level, host_lvl, m;
  logic [2:0] s_axi_awprot, s_axi_arprot;
  logic [31:0] s_axi_wdata, s_axi_rdata, rv, v, e;
  logic [3:0] s_axi_wstrb, seq_trigger;
  logic [1:0] s_axi_bresp, s_axi_rresp, irq_pending;
  int failures, n_checks, seed, i;
  gpio_port_function_mux dut (.*);
  pad_model host (.*);
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic close_out;
    if (failures == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : close_out
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] st,
                    input logic [1:0] er);
    logic ad, wd;
    ad = 1'b0;
    wd = 1'b0;
    s_axi_awaddr <= a; s_axi_wdata <= d; s_axi_wstrb <= st;
    s_axi_awvalid <= 1'b1; s_axi_wvalid <= 1'b1; s_axi_bready <= 1'b1;
    do begin
      @(posedge core_clk);
      if (s_axi_awvalid && s_axi_awready) begin ad = 1'b1; s_axi_awvalid <= 1'b0; end
      if (s_axi_wvalid && s_axi_wready) begin wd = 1'b1; s_axi_wvalid <= 1'b0; end
    end while (!(ad && wd));
    do @(posedge core_clk); while (!s_axi_bvalid);
    chk({30'h0, s_axi_bresp}, {30'h0, er});
    s_axi_bready <= 1'b0;
    @(posedge core_clk);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [1:0] er, input logic [31:0] ed);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= !slow;
    do @(posedge core_clk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge core_clk); while (!s_axi_rvalid);
    // a late rready makes the slave hold its answer
    if (slow) begin
      s_axi_rready <= 1'b1;
      @(posedge core_clk);
    end
    chk({30'h0, s_axi_rresp}, {30'h0, er});
    chk(s_axi_rdata, ed);
    s_axi_rready <= 1'b0;
    @(posedge core_clk);
  endtask : rd
  // expected drivers: triggers and clock inputs float, irq and por forced
  function automatic logic [31:0] exp_oe(input logic [15:0] s, input logic [7:0] en);
    logic [1:0] c;
    exp_oe = {24'h0, en};
    for (int j = 2; j < 8; j++) begin
      c = s[2*j+:2];
      exp_oe[j] = (c == CODE_01 || (c == CODE_11 && (j == 2 || j == 5))) ? 1'b0 :
                  (c == CODE_11 || (j == 2 && c == CODE_00)) ? 1'b1 : en[j];
    end
  endfunction : exp_oe
  // lines working as plain gpio under a select word
  function automatic logic [7:0] gpio_mask(input logic [15:0] s);
    gpio_mask = 8'h03;
    for (int j = 3; j < 8; j++) begin
      gpio_mask[j] = (s[2*j+:2] == CODE_00);
    end
  endfunction : gpio_mask
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    rv = $random(seed);
    irq_pending <= rv[1:0]; por_flag <= rv[2]; ext_sync_level <= rv[10:3];
    host_lvl <= rv[18:11];
  end
  initial begin
    repeat (20000) @(posedge core_clk);
    failures++;
    close_out;
  end
  initial begin
    seed = 8669; failures = 0; n_checks = 0; arst_n = 1'b0; slow = 1'b0;
    s_axi_awvalid = 1'b0; s_axi_wvalid = 1'b0; s_axi_bready = 1'b0; s_axi_arvalid = 1'b0;
    s_axi_rready = 1'b0; s_axi_awaddr = 8'h00; s_axi_araddr = 8'h00; s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'h0; s_axi_awprot = 3'h0; s_axi_arprot = 3'h0;
    irq_pending = 2'h0; por_flag = 1'b0; ext_sync_level = 8'h00; host_lvl = 8'h00;
    repeat (2) @(posedge core_clk);
    arst_n <= 1'b1;
    rd(FUNC_SEL_ADDR, RESP_OKAY, 32'h0);
    chk({24'h0, pin_oe}, exp_oe(16'h0000, 8'h00));
    rd(DRIVE_EN_ADDR, RESP_OKAY, 32'h0);
    wr(8'h3c, 32'hffff, 4'hf, RESP_SLVERR);
    rd(8'h3c, RESP_SLVERR, 32'h0);
    wr(FUNC_SEL_ADDR, 32'h5555, 4'hf, RESP_OKAY);
    wr(FUNC_SEL_ADDR, 32'haaaa, 4'h2, RESP_OKAY);
    rd(FUNC_SEL_ADDR, RESP_OKAY, 32'haa55);
    for (i = 0; i < 44; i++) begin
      v = $random(seed);
      e = $random(seed);
      if (i < 4) v = {16'h0, {8{i[1:0]}}};
      slow = e[8];
      wr(DRIVE_EN_ADDR, {24'h0, e[7:0]}, 4'hf, RESP_OKAY);
      wr(OUT_DATA_ADDR, {24'h0, e[23:16]}, 4'hf, RESP_OKAY);
      wr(FUNC_SEL_ADDR, v, 4'hf, RESP_OKAY);
      rd(FUNC_SEL_ADDR, RESP_OKAY, {16'h0, v[15:0]});
      rd(OUT_DATA_ADDR, RESP_OKAY, {24'h0, e[23:16]});
      repeat (6) @(posedge core_clk);
      chk({24'h0, pin_oe}, exp_oe(v[15:0], e[7:0]));
      m = gpio_mask(v[15:0]);
      chk({24'h0, pin_out & m}, {24'h0, e[23:16] & m});
      chk({24'h0, gpio_in_level & ~(m & ~e[7:0])}, {24'h0, e[23:16] & m & e[7:0]});
    end
    // reset in mid-run must bring every selector back to code 00
    arst_n <= 1'b0;
    repeat (2) @(posedge core_clk);
    arst_n <= 1'b1;
    rd(FUNC_SEL_ADDR, RESP_OKAY, 32'h0);
    rd(DRIVE_EN_ADDR, RESP_OKAY, 32'h0);
    chk({24'h0, pin_oe}, exp_oe(16'h0000, 8'h00));
    close_out;
  end
endmodule : tb_gpio_port_function_mux
`default_nettype wire
